//--- rtl/chopping_current_regulator.v
// PWM chopping current regulator for one H-bridge with APB control and status.
`timescale 1ns/1ps
`include "chop_regulator_map.vh"
module chopping_current_regulator (
  input  wire        clock,
  input  wire        reset,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        sleep_request_n,
  input  wire        direction_input,
  input  wire        enable_input,
  input  wire        drive_input_a,
  input  wire        drive_input_b,
  input  wire [1:0]  off_time_select,
  input  wire [1:0]  decay_select,
  input  wire        trip_reached,
  input  wire        valley_reached,
  input  wire        current_near_zero,
  input  wire        trip_step_down,
  input  wire        fault_detected,
  output reg         high_side_a,
  output reg         low_side_a,
  output reg         high_side_b,
  output reg         low_side_b,
  input  wire        fault_out_n_in,
  output wire        fault_out_n_out,
  output reg         fault_out_n_oe_n
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_BLANK = 3'h1;
  localparam [2:0] ST_DRIVE = 3'h2;
  localparam [2:0] ST_FAST  = 3'h3;
  localparam [2:0] ST_SLOW  = 3'h4;
  localparam [2:0] ST_HIZ   = 3'h5;

  reg  [1:0]        ctrl_reg;
  reg  [2:0]        state_reg;
  reg  [2:0]        state_next;
  reg  [1:0]        off_sel_reg;
  reg  [1:0]        decay_reg;
  reg               sample_pending_reg;
  reg  [3:0]        share_reg;
  reg  [3:0]        share_used_reg;
  reg               overshoot_reg;
  reg               step_pending_reg;
  reg               dir_reg;
  reg  [`CNT_W-1:0] drive_len_reg;
  reg  [`CNT_W-1:0] decay_interval;
  reg  [3:0]        share_calc;
  reg               drive_req;
  reg               drive_fwd;
  reg               brake_low;
  reg               brake_high;
  wire [15:0]       fast_prod;
  wire [`CNT_W-1:0] fast_len;
  wire [`CNT_W-1:0] blank_count;
  wire              blank_done;
  wire [`CNT_W-1:0] off_count;
  wire              off_done;
  wire              active;
  wire              decay_start;
  wire              blank_load;
  wire              in_fast_window;

  assign active = sleep_request_n & ~fault_detected;

  // --------------------------------------------------------------------------
  // Select pin sampling
  // --------------------------------------------------------------------------
  // latch pins on wake
  always @(posedge clock) begin
    if (reset) begin
      sample_pending_reg <= 1'b1;
      off_sel_reg        <= `LVL_LOW;
      decay_reg          <= `DECAY_DYNAMIC;
    end else if (!sleep_request_n) begin
      sample_pending_reg <= 1'b1;
    end else if (sample_pending_reg) begin
      sample_pending_reg <= 1'b0;
      off_sel_reg        <= off_time_select;
      decay_reg          <= decay_select;
    end
  end

  always @* begin
    case (off_sel_reg)
      `LVL_LOW:  decay_interval = `OFF_LOW_CYC;
      `LVL_HIGH: decay_interval = `OFF_HIGH_CYC;
      `LVL_OPEN: decay_interval = `OFF_OPEN_CYC;
      default:   decay_interval = `OFF_RES_CYC;
    endcase
  end

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  always @* begin
    drive_req  = 1'b0;
    drive_fwd  = 1'b0;
    brake_low  = 1'b0;
    brake_high = 1'b0;
    if (ctrl_reg[`CTRL_VARIANT_BIT]) begin
      drive_req  = drive_input_a ^ drive_input_b;
      drive_fwd  = drive_input_a;
      brake_low  = ~drive_input_a & ~drive_input_b;
      brake_high = drive_input_a & drive_input_b;
    end else begin
      drive_req  = enable_input;
      drive_fwd  = direction_input;
    end
  end

  // --------------------------------------------------------------------------
  // Decay share
  // --------------------------------------------------------------------------
  assign decay_start = (state_reg == ST_DRIVE) && trip_reached && active && drive_req
                       && ctrl_reg[`CTRL_REG_EN_BIT] && (drive_fwd == dir_reg);
  // A direction change inside blanking reloads the timer and takes the new direction.
  assign blank_load  = (state_next == ST_BLANK) && (state_reg != ST_BLANK || drive_fwd != dir_reg);

  always @* begin
    share_calc = share_reg;
    if (overshoot_reg && share_reg != `SHARE_FULL) begin
      share_calc = share_reg + 4'h1;
    end else if (!overshoot_reg && drive_len_reg >= decay_interval && share_reg != 4'h0) begin
      share_calc = share_reg - 4'h1;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      share_reg        <= `SHARE_RESET;
      share_used_reg   <= `SHARE_RESET;
      overshoot_reg    <= 1'b0;
      step_pending_reg <= 1'b0;
    end else begin
      // A step captured in the same cycle as decay start is kept for the next one.
      step_pending_reg <= trip_step_down | (step_pending_reg & ~(decay_start && decay_reg == `DECAY_DYNAMIC));
      if (state_reg == ST_BLANK && blank_done) begin
        overshoot_reg <= trip_reached;
      end
      if (decay_start) begin
        case (decay_reg)
          `DECAY_DYNAMIC: begin
            share_reg      <= share_calc;
            share_used_reg <= step_pending_reg ? `SHARE_FULL : share_calc;
          end
          `DECAY_MIXED:   share_used_reg <= `SHARE_MIXED;
          `DECAY_FAST:    share_used_reg <= `SHARE_FULL;
          default:        share_used_reg <= 4'h0;
        endcase
      end
    end
  end

  assign fast_prod      = ({4'h0, decay_interval} * {12'h000, share_used_reg}) / 16'h000A;
  assign fast_len       = fast_prod[`CNT_W-1:0];
  assign in_fast_window = (off_count >= (decay_interval - fast_len)) && (fast_len != {`CNT_W{1'b0}});

  // --------------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------------
  interval_timer #(.W(`CNT_W)) blank_timer (
    .clock   (clock),
    .reset   (reset),
    .load    (blank_load),
    .value   (`BLANK_CYC - 12'h001),
    .count   (blank_count),
    .expired (blank_done)
  );

  interval_timer #(.W(`CNT_W)) off_timer (
    .clock   (clock),
    .reset   (reset),
    .load    (decay_start),
    .value   (decay_interval - {{(`CNT_W-1){1'b0}}, 1'b1}),
    .count   (off_count),
    .expired (off_done)
  );

  // --------------------------------------------------------------------------
  // Regulation state machine
  // --------------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    if (!active || !ctrl_reg[`CTRL_REG_EN_BIT] || !drive_req) begin
      state_next = (active && drive_req) ? ST_DRIVE : ST_IDLE;
    end else if (state_reg != ST_IDLE && drive_fwd != dir_reg) begin
      state_next = ST_BLANK;
    end else begin
      case (state_reg)
        ST_IDLE:  state_next = ST_BLANK;
        ST_BLANK: state_next = blank_done ? ST_DRIVE : ST_BLANK;
        ST_DRIVE: begin
          if (trip_reached) begin
            if (decay_reg == `DECAY_RIPPLE) begin
              state_next = ST_SLOW;
            end else begin
              state_next = ST_FAST;
            end
          end
        end
        ST_FAST: begin
          if (decay_reg == `DECAY_RIPPLE) begin
            state_next = ST_SLOW;
          end else if (off_done) begin
            state_next = ST_BLANK;
          end else if (!in_fast_window) begin
            state_next = ST_SLOW;
          end else if (current_near_zero) begin
            state_next = ST_HIZ;
          end
        end
        ST_SLOW: begin
          if (decay_reg == `DECAY_RIPPLE) begin
            state_next = valley_reached ? ST_BLANK : ST_SLOW;
          end else if (off_done) begin
            state_next = ST_BLANK;
          end
        end
        ST_HIZ:   state_next = off_done ? ST_BLANK : ST_HIZ;
        default:  state_next = ST_IDLE;
      endcase
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      dir_reg       <= 1'b1;
      drive_len_reg <= {`CNT_W{1'b0}};
    end else begin
      state_reg <= state_next;
      if (blank_load) begin
        dir_reg       <= drive_fwd;
        drive_len_reg <= {`CNT_W{1'b0}};
      end else if ((state_reg == ST_BLANK || state_reg == ST_DRIVE) && drive_len_reg != {`CNT_W{1'b1}}) begin
        drive_len_reg <= drive_len_reg + {{(`CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Gate drive
  // --------------------------------------------------------------------------
  // forward is A high, B low
  always @(posedge clock) begin
    if (reset || !active) begin
      {high_side_a, low_side_a, high_side_b, low_side_b} <= 4'h0;
    end else begin
      case (state_next)
        ST_BLANK, ST_DRIVE: begin
          {high_side_a, low_side_a, high_side_b, low_side_b} <= drive_fwd ? 4'h9 : 4'h6;
        end
        ST_FAST: begin
          {high_side_a, low_side_a, high_side_b, low_side_b} <= dir_reg ? 4'h6 : 4'h9;
        end
        ST_SLOW: {high_side_a, low_side_a, high_side_b, low_side_b} <= 4'h5;
        ST_IDLE: begin
          if (drive_req) begin
            {high_side_a, low_side_a, high_side_b, low_side_b} <= drive_fwd ? 4'h9 : 4'h6;
          end else if (brake_low) begin
            {high_side_a, low_side_a, high_side_b, low_side_b} <= 4'h5;
          end else if (brake_high) begin
            {high_side_a, low_side_a, high_side_b, low_side_b} <= 4'hA;
          end else begin
            {high_side_a, low_side_a, high_side_b, low_side_b} <= 4'h0;
          end
        end
        default: {high_side_a, low_side_a, high_side_b, low_side_b} <= 4'h0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Fault output
  // --------------------------------------------------------------------------
  assign fault_out_n_out = 1'b0;

  always @(posedge clock) begin
    if (reset) begin
      fault_out_n_oe_n <= 1'b1;
    end else begin
      fault_out_n_oe_n <= ~fault_detected;
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  assign pready = 1'b1;

  always @(posedge clock) begin
    if (reset) begin
      ctrl_reg <= `CTRL_RESET;
      prdata   <= 32'h00000000;
      pslverr  <= 1'b0;
    end else begin
      if (psel && !penable) begin
        pslverr <= (paddr != `REG_CTRL) && (paddr != `REG_STATUS);
        case (paddr)
          `REG_CTRL:   prdata <= {30'h00000000, ctrl_reg};
          `REG_STATUS: prdata <= {19'h00000, ~sleep_request_n, fault_out_n_in, share_reg,
                                  off_sel_reg, decay_reg, state_reg};
          default:     prdata <= 32'h00000000;
        endcase
      end
      if (psel && penable && pwrite && paddr == `REG_CTRL) begin
        ctrl_reg <= pwdata[1:0];
      end
    end
  end

endmodule

//--- rtl/chop_regulator_map.vh
// Constants for the chopping current regulator: timing, pin codes and register map.
`ifndef CHOP_REGULATOR_MAP_VH
`define CHOP_REGULATOR_MAP_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_MHZ            100
`define OFF_LOW_US         7
`define OFF_HIGH_US        16
`define OFF_OPEN_US        24
`define OFF_RES_US         32
`define BLANK_US           1
// Cycle counts at the clock rate above, sized to the interval counters.
`define OFF_LOW_CYC        12'h2BC
`define OFF_HIGH_CYC       12'h640
`define OFF_OPEN_CYC       12'h960
`define OFF_RES_CYC        12'hC80
`define BLANK_CYC          12'h064
`define CNT_W              12

// ----------------------------------------------------------------------------
// Fast-decay share in tenths of the off interval
// ----------------------------------------------------------------------------
`define MIXED_FAST_PCT     30
`define SHARE_FULL         4'hA
`define SHARE_MIXED        4'h3
`define SHARE_RESET        4'h3

// ----------------------------------------------------------------------------
// Four-level pin codes
// ----------------------------------------------------------------------------
`define LVL_LOW            2'h0
`define LVL_HIGH           2'h1
`define LVL_OPEN           2'h2
`define LVL_RES            2'h3
`define DECAY_DYNAMIC      2'h0
`define DECAY_RIPPLE       2'h1
`define DECAY_MIXED        2'h2
`define DECAY_FAST         2'h3

// ----------------------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------------------
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define CTRL_VARIANT_BIT   0
`define CTRL_REG_EN_BIT    1
`define CTRL_RESET         2'h2

`endif

//--- rtl/interval_timer.v
// Down-counting interval timer used for the blanking and off intervals.
`timescale 1ns/1ps
module interval_timer #(
  parameter W = 12
) (
  input  wire         clock,
  input  wire         reset,
  input  wire         load,
  input  wire [W-1:0] value,
  output wire [W-1:0] count,
  output wire         expired
);

  reg [W-1:0] count_reg;

  always @(posedge clock) begin
    if (reset) begin
      count_reg <= {W{1'b0}};
    end else if (load) begin
      count_reg <= value;
    end else if (count_reg != {W{1'b0}}) begin
      count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign count   = count_reg;
  assign expired = (count_reg == {W{1'b0}});

endmodule

//--- sim/regulator_checker_sva.sv
// Concurrent checks on the ports of the chopping current regulator.
`timescale 1ns/1ps
module regulator_checker (
  input wire       clock,
  input wire       reset,
  input wire [7:0] paddr,
  input wire       psel,
  input wire       penable,
  input wire       pslverr,
  input wire       sleep_request_n,
  input wire       direction_input,
  input wire       enable_input,
  input wire       trip_reached,
  input wire       fault_detected,
  input wire       high_side_a,
  input wire       low_side_a,
  input wire       high_side_b,
  input wire       low_side_b,
  input wire       fault_out_n_oe_n
);
  wire [3:0]  gates = {high_side_a, low_side_a, high_side_b, low_side_b};
  reg  [11:0] fwd_cnt_reg;
  reg  [11:0] slow_cnt_reg;

  // Counts consecutive forward-drive and slow-decay cycles, saturating.
  always @(posedge clock) begin
    if (reset) begin
      fwd_cnt_reg  <= 12'h000;
      slow_cnt_reg <= 12'h000;
    end else begin
      fwd_cnt_reg  <= (gates != 4'h9) ? 12'h000 : fwd_cnt_reg + {11'h000, fwd_cnt_reg != 12'hFFF};
      slow_cnt_reg <= (gates != 4'h5) ? 12'h000 : slow_cnt_reg + {11'h000, slow_cnt_reg != 12'hFFF};
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_early_drive;
    gates == 4'h9 && fwd_cnt_reg < 12'd99 && direction_input && enable_input && sleep_request_n && !fault_detected;
  endsequence
  sequence s_late_trip;
    gates == 4'h9 && fwd_cnt_reg >= 12'd110 && trip_reached && sleep_request_n && !fault_detected;
  endsequence
  sequence s_decay;
    low_side_a && !high_side_a;
  endsequence

  chk_trip_decay: assert property (s_late_trip |=> s_decay)
    else $error("no decay after trip");
  chk_blank_min: assert property (s_early_drive ##1 $stable(direction_input) |-> !(low_side_a && !high_side_a))
    else $error("drive ended inside blanking");
  chk_slow_bound: assert property (slow_cnt_reg <= 12'd3200)
    else $error("slow decay outlasted off time");
  chk_slow_pair: assert property (low_side_a && low_side_b |-> !high_side_a && !high_side_b)
    else $error("high side on in slow decay");
  chk_fault_pull: assert property (fault_detected |=> !fault_out_n_oe_n)
    else $error("fault pin not pulled");
  chk_fault_free: assert property (!fault_detected |=> fault_out_n_oe_n)
    else $error("fault pin not released");
  chk_sleep_hiz: assert property (!sleep_request_n || fault_detected |=> gates == 4'h0)
    else $error("bridge on in sleep or fault");
  chk_bad_addr: assert property (psel && !penable && paddr != 8'h00 && paddr != 8'h04 |=> pslverr)
    else $error("unmapped access not flagged");
endmodule

bind chopping_current_regulator regulator_checker u_checker (
  .clock(clock), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pslverr(pslverr),
  .sleep_request_n(sleep_request_n), .direction_input(direction_input), .enable_input(enable_input),
  .trip_reached(trip_reached), .fault_detected(fault_detected), .high_side_a(high_side_a),
  .low_side_a(low_side_a), .high_side_b(high_side_b), .low_side_b(low_side_b),
  .fault_out_n_oe_n(fault_out_n_oe_n));

//--- sim/host_controller.sv
// Behavioural model of the controller that drives the bridge command pins.
`timescale 1ns/1ps
module host_controller (
  input  wire clock,
  output reg  sleep_request_n,
  output reg  enable_input,
  output reg  direction_input,
  output reg  drive_input_a,
  output reg  drive_input_b
);
  initial {sleep_request_n, enable_input, direction_input, drive_input_a, drive_input_b} = 5'h10;

  task send(input [4:0] v);
    @(posedge clock);
    {sleep_request_n, enable_input, direction_input, drive_input_a, drive_input_b} <= v;
  endtask
endmodule

//--- sim/testbench.sv
// Self-checking testbench for the chopping current regulator.
`timescale 1ns/1ps
module testbench;
  localparam [3:0] FWD = 4'h9, REV = 4'h6, SLOW = 4'h5;
  reg         clock, reset, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [1:0]  off_time_select, decay_select;
  reg         trip_reached, valley_reached, current_near_zero, trip_step_down, fault_detected, er;
  wire        pready, pslverr, fault_out_n_out, fault_out_n_oe_n;
  wire        sleep_request_n, direction_input, enable_input, drive_input_a, drive_input_b;
  wire        high_side_a, low_side_a, high_side_b, low_side_b;
  wire [31:0] prdata;
  wire        fault_pin = fault_out_n_oe_n ? 1'b1 : fault_out_n_out;
  wire [3:0]  g = {high_side_a, low_side_a, high_side_b, low_side_b};
  int         fail_count, samples_checked, n, m;
  int         us[4] = '{7, 16, 24, 32};
  reg  [3:0]  two_in[4] = '{SLOW, REV, FWD, 4'hA};
  reg  [3:0]  dir_en[4] = '{4'h0, FWD, REV, 4'h0};
  reg  [2:0]  dir_cmd[4] = '{3'b101, 3'b111, 3'b110, 3'b011};

  host_controller ctl (.clock(clock), .sleep_request_n(sleep_request_n), .enable_input(enable_input),
    .direction_input(direction_input), .drive_input_a(drive_input_a), .drive_input_b(drive_input_b));
  chopping_current_regulator dut (.clock(clock), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sleep_request_n(sleep_request_n), .direction_input(direction_input),
    .enable_input(enable_input), .drive_input_a(drive_input_a), .drive_input_b(drive_input_b),
    .off_time_select(off_time_select), .decay_select(decay_select), .trip_reached(trip_reached),
    .valley_reached(valley_reached), .current_near_zero(current_near_zero),
    .trip_step_down(trip_step_down), .fault_detected(fault_detected), .high_side_a(high_side_a),
    .low_side_a(low_side_a), .high_side_b(high_side_b), .low_side_b(low_side_b),
    .fault_out_n_in(fault_pin), .fault_out_n_out(fault_out_n_out), .fault_out_n_oe_n(fault_out_n_oe_n));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task check(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task near(input int v, input int e);
    check(v >= e - 2 && v <= e + 2, 1);
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task idle(input int k);
    repeat (k) @(negedge clock);
  endtask
  task waitv(input [3:0] v);
    n = 0;
    while (g !== v && n < 9999) begin @(negedge clock); n++; end
    check(n < 9999, 1);
  endtask
  task cnt(input [3:0] v);
    n = 0;
    while (g === v && n < 9999) begin @(negedge clock); n++; end
    check(n < 9999, 1);
  endtask
  // Select pins are latched on leaving sleep, so every mode change goes through a sleep pulse.
  task wake(input [1:0] t, input [1:0] d);
    @(posedge clock) begin off_time_select <= t; decay_select <= d; end
    ctl.send(5'b00000);
    repeat (3) @(posedge clock);
    ctl.send(5'b11100);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #900000;
    fail_count++;
    report_and_stop;
  end

  initial begin
    reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; off_time_select = 0;
    decay_select = 0; trip_reached = 0; valley_reached = 0; current_near_zero = 0;
    trip_step_down = 0; fault_detected = 0; fail_count = 0; samples_checked = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    apb(0, 8'h00, 0); check(rd, 32'h2);
    apb(0, 8'h04, 0); check(rd & 32'h1FF8, 32'h980);
    check(fault_pin, 1);
    apb(0, 8'h08, 0); check(rd, 0); check(er, 1);
    apb(1, 8'h04, 32'hFFFF); check(er, 0);
    apb(1, 8'h00, 0); apb(0, 8'h00, 0); check(rd, 0);
    apb(1, 8'h00, 32'h2);
    @(posedge clock) trip_reached <= 1'b1;
    ctl.send(5'b11100);
    waitv(FWD); cnt(FWD); check(n >= 100 && n <= 103, 1);
    cnt(REV); near(n, 280);
    @(posedge clock) trip_reached <= 1'b0;
    waitv(FWD); apb(0, 8'h04, 0); check(rd[10:7], 4);
    idle(800);
    @(posedge clock) trip_reached <= 1'b1;
    cnt(FWD);
    @(posedge clock) trip_reached <= 1'b0;
    waitv(FWD); apb(0, 8'h04, 0); check(rd[10:7], 3);
    @(posedge clock) trip_step_down <= 1'b1;
    @(posedge clock) begin trip_step_down <= 1'b0; trip_reached <= 1'b1; end
    cnt(FWD); cnt(REV); near(n, 700);
    for (int t = 0; t < 4; t++) begin
      wake(t, 2);
      apb(0, 8'h04, 0); check(rd[6:3], {t[1:0], 2'h2});
      waitv(FWD); cnt(FWD); cnt(REV); m = n; cnt(SLOW);
      near(m, us[t] * 30);
      near(m + n, us[t] * 100);
    end
    wake(0, 3); waitv(REV); idle(5);
    @(posedge clock) current_near_zero <= 1'b1;
    idle(2); check(g, 0);
    @(posedge clock) current_near_zero <= 1'b0;
    wake(0, 1); waitv(FWD); cnt(FWD); check(g, SLOW);
    @(posedge clock) trip_reached <= 1'b0;
    idle(1000); check(g, SLOW);
    @(posedge clock) valley_reached <= 1'b1;
    idle(3); check(g, FWD);
    @(posedge clock) valley_reached <= 1'b0;
    apb(1, 8'h00, 32'h3);
    for (int i = 0; i < 4; i++) begin
      ctl.send({3'b100, i[1:0]}); idle(3); check(g, two_in[i]);
    end
    apb(1, 8'h00, 32'h2);
    for (int i = 0; i < 4; i++) begin
      ctl.send({dir_cmd[i], 2'b00}); idle(3); check(g, dir_en[i]);
    end
    ctl.send(5'b11100); idle(150);
    @(posedge clock) fault_detected <= 1'b1;
    idle(2); check({fault_pin, g}, 5'h00);
    apb(0, 8'h04, 0); check(rd[11], 0);
    @(posedge clock) fault_detected <= 1'b0;
    idle(2); check(fault_pin, 1);
    report_and_stop;
  end
endmodule
